//--- logic/qhs_consts.svh
// constants for the quickstart hold sequencer
`ifndef QHS_CONSTS_SVH
`define QHS_CONSTS_SVH
`define QHS_CLK_HZ          40000000
`define QHS_HOLD_LIMIT_MS   20000
`define QHS_HOLD_CYCLES     ((`QHS_HOLD_LIMIT_MS / 1000) * `QHS_CLK_HZ)
`define QHS_SPEED_WAIT_MS   150
`define QHS_SPEED_CYCLES    ((`QHS_SPEED_WAIT_MS * `QHS_CLK_HZ) / 1000)
`define QHS_CREEP_LIMIT_MM  7
`define QHS_ERR_NONE        8'h00
`define QHS_ERR_TIMEOUT     8'h01
`define QHS_ERR_TRAVEL      8'h02
`define QHS_ERR_CREEP       8'h03
`endif

//--- logic/qhs_ctrl.sv
// lift controller end: drives the quickstart start sequence
`timescale 1ns/10ps
`include "qhs_consts.svh"
module qhs_ctrl
    import qhs_pkg::*;
#(
    parameter int unsigned SPEED_CYCLES = `QHS_SPEED_CYCLES
) (
    // clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    // user side
    input  wire logic       door_closing_in,
    input  wire logic       door_closed_in,
    input  wire logic       direction_in,
    input  wire logic [1:0] speed_sel_in,
    input  wire logic       trip_end_in,
    output logic            travelling_out,
    // link
    qhs_link_if.ctrl        link
);
    typedef enum logic [1:0] {
        C_IDLE = 2'b00, C_HOLD = 2'b01, C_GAP = 2'b11, C_RUN = 2'b10
    } qhs_ctrl_e;
    typedef struct packed {
        logic [1:0] rdy_s1, brk_s1;
        qhs_ctrl_e  st;
        logic       en, dir, hold, mot, run;
        logic [1:0] sel;
        logic [2:0] spd;
    } qhs_ctrl_s;
    qhs_ctrl_s r;
    qhs_ctrl_s next_r;

    always_comb begin
        next_r = r;
        next_r.rdy_s1 = {r.rdy_s1[0], link.drive_ready};
        next_r.brk_s1 = {r.brk_s1[0], link.brake_release};
        case (r.st)
            C_IDLE: if (door_closing_in) begin
                next_r.en   = 1'b1;
                next_r.dir  = direction_in;
                next_r.hold = 1'b1;
                next_r.mot  = 1'b1;
                next_r.st   = C_HOLD;
            end
            C_HOLD: if (door_closed_in && r.brk_s1[1]) begin
                next_r.hold = 1'b0;
                next_r.sel  = (speed_sel_in == 2'h0) ? 2'h1 : speed_sel_in;
                next_r.st   = C_GAP;
            end
            C_GAP: begin
                next_r.run = 1'b1;
                next_r.spd = {r.sel == 2'h1, r.sel == 2'h2, r.sel == 2'h3};
                next_r.st  = C_RUN;
            end
            C_RUN: if (trip_end_in || !r.rdy_s1[1]) begin
                next_r = '0;
                next_r.rdy_s1 = {r.rdy_s1[0], link.drive_ready};
                next_r.brk_s1 = {r.brk_s1[0], link.brake_release};
                next_r.st = C_IDLE;
            end
            default: next_r.st = C_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // exactly one speed line, only after hold dropped
    assign link.controller_enable  = r.en;
    assign link.travel_direction   = r.dir;
    assign link.hold_zero          = r.hold;
    assign link.motor_energised    = r.mot;
    assign link.positioning_speed  = r.spd[2];
    assign link.intermediate_speed = r.spd[1];
    assign link.high_speed         = r.spd[0];
    assign travelling_out          = r.run;
endmodule

//--- logic/qhs_drive.sv
// drive end: quickstart hold sequencing and supervision
// Overview of operation
// - control asserts enable, direction, hold on door closing
// - drive raises ready after those three inputs; code raises it on enable with hold or with a speed line, direction is not read
// - control energises motor at hold start
// - brake output opens once motor energised
// - hold with brake open regulates speed zero
// - door closed: drop hold, one speed
// - speed within 150 ms of hold release
// - connect speeds only after hold released
// - hold beyond 20 s gives timeout fault
// - hold during travel gives travel fault
// - creep beyond 7 mm gives alarm fault
// - encoder supervision starts after hold off
// - telegram bits answered by travel active
// - telegram brake status bit shows brake open
// - telegram: speed bits set, zero bit cleared
// - fieldbus: enable voltage, disable operation, zero
// - fieldbus: enable operation opens brake
// - fieldbus: confirm brake then target speed
// - energise and open brake during door closing
`timescale 1ns/10ps
`include "qhs_consts.svh"
module qhs_drive
    import qhs_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = `QHS_HOLD_CYCLES,
    parameter int unsigned POS_W       = 16,
    parameter int unsigned CREEP_MM    = `QHS_CREEP_LIMIT_MM
) (
    // clock and reset
    input  wire logic               mclk_in,
    input  wire logic               rstn_in,
    // link
    qhs_link_if.drive               link,
    // motor side
    input  wire logic signed [POS_W-1:0] position_mm_in,
    input  wire logic               fault_clear_in,
    output logic                    zero_speed_reg_out,
    output logic                    encoder_sup_start_out,
    output logic [7:0]              error_code_out,
    output logic                    fault_out
);
    typedef struct packed {
        qhs_state_e              state;
        logic [31:0]             hold_cnt;
        logic signed [POS_W-1:0] pos_ref;
        logic                    ready;
        logic                    brake;
        logic                    active;
        logic                    zero_reg;
        logic                    sup_start;
        logic                    fault;
        logic [7:0]              err;
    } qhs_drive_s;

    qhs_drive_s              r;
    qhs_drive_s              next_r;
    logic [4:0]              raw;
    logic [4:0]              synced;
    logic                    en;
    logic                    hold;
    logic                    spd;
    logic                    mot;
    logic                    clr;
    logic signed [POS_W-1:0] delta;

    // link inputs except direction, and the clear input, pass two flip-flops first
    assign raw = {link.controller_enable, link.hold_zero,
                  link.positioning_speed | link.intermediate_speed
                  | link.high_speed,
                  link.motor_energised, fault_clear_in};

    qhs_sync2 #(
        .W (5)
    ) qhs_sync2_i (
        .mclk_in (mclk_in),
        .rstn_in (rstn_in),
        .d_in    (raw),
        .q_out   (synced)
    );

    assign {en, hold, spd, mot, clr} = synced;

    always_comb begin
        next_r = r;
        delta = position_mm_in - r.pos_ref;
        next_r.sup_start = 1'b0;
        case (r.state)
            QHS_IDLE: begin
                next_r.hold_cnt = 32'h0;
                if (en && hold) begin
                    next_r.state = QHS_READY;
                    next_r.ready = 1'b1;
                    next_r.active = 1'b1;
                end else if (en && spd) begin
                    next_r.state  = QHS_TRAVEL;
                    next_r.ready  = 1'b1;
                    next_r.active = 1'b1;
                end
            end
            QHS_READY: begin
                if (!en) begin
                    next_r.state = QHS_IDLE;
                end else if (mot) begin
                    next_r.brake    = 1'b1;
                    next_r.zero_reg = 1'b1;
                    next_r.pos_ref  = position_mm_in;
                    next_r.state    = QHS_HOLD;
                end
                if (r.hold_cnt >= HOLD_CYCLES - 1) begin
                    next_r.state = QHS_FAULT;
                    next_r.err   = `QHS_ERR_TIMEOUT;
                end else begin
                    next_r.hold_cnt = r.hold_cnt + 32'h1;
                end
            end
            QHS_HOLD: begin
                if (!en) begin
                    next_r.state = QHS_IDLE;
                end else if (!hold) begin
                    next_r.zero_reg  = 1'b0;
                    next_r.sup_start = 1'b1;
                    next_r.state     = QHS_TRAVEL;
                end else if (r.hold_cnt >= HOLD_CYCLES - 1) begin
                    next_r.state = QHS_FAULT;
                    next_r.err   = `QHS_ERR_TIMEOUT;
                end else if (delta > $signed(POS_W'(CREEP_MM))
                    || delta < -$signed(POS_W'(CREEP_MM))) begin
                    next_r.state = QHS_FAULT;
                    next_r.err   = `QHS_ERR_CREEP;
                end else begin
                    next_r.hold_cnt = r.hold_cnt + 32'h1;
                end
            end
            QHS_TRAVEL: begin
                next_r.hold_cnt = 32'h0;
                if (hold) begin
                    next_r.state = QHS_FAULT;
                    next_r.err   = `QHS_ERR_TRAVEL;
                end else if (!en) begin
                    next_r.state = QHS_IDLE;
                end else if (mot) begin
                    next_r.brake = 1'b1;
                end
            end
            QHS_FAULT: begin
                if (clr && !en) begin
                    next_r.state = QHS_IDLE;
                    next_r.err   = `QHS_ERR_NONE;
                end
            end
            default: next_r.state = QHS_IDLE;
        endcase
        if (next_r.state == QHS_IDLE || next_r.state == QHS_FAULT) begin
            next_r.ready    = 1'b0;
            next_r.brake    = 1'b0;
            next_r.active   = 1'b0;
            next_r.zero_reg = 1'b0;
        end
        next_r.fault = (next_r.state == QHS_FAULT);
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            r       <= '0;
            r.state <= QHS_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign link.drive_ready   = r.ready;
    assign link.brake_release = r.brake;
    assign link.travel_active = r.active;
    assign zero_speed_reg_out    = r.zero_reg;
    assign encoder_sup_start_out = r.sup_start;
    assign error_code_out        = r.err;
    assign fault_out             = r.fault;
endmodule

// two-stage synchroniser for signals from outside the clock domain
module qhs_sync2
    import qhs_pkg::*;
#(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rstn_in,
    // asynchronous side
    input  wire logic [W-1:0] d_in,
    // synchronised side
    output logic [W-1:0]      q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } qhs_sync2_s;

    qhs_sync2_s r;
    qhs_sync2_s next_r;

    // only stage two leaves the module
    always_comb begin
        next_r    = r;
        next_r.s1 = d_in;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q_out = r.s2;
endmodule

//--- logic/qhs_link_if.sv
// link between lift controller and drive sequencer
`timescale 1ns/10ps
interface qhs_link_if;
    logic       controller_enable;
    logic       travel_direction;
    logic       hold_zero;
    logic       positioning_speed;
    logic       intermediate_speed;
    logic       high_speed;
    logic       motor_energised;
    logic       drive_ready;
    logic       brake_release;
    logic       travel_active;
    modport drive (
        input  controller_enable, travel_direction, hold_zero,
               positioning_speed, intermediate_speed, high_speed,
               motor_energised,
        output drive_ready, brake_release, travel_active
    );
    modport ctrl (
        output controller_enable, travel_direction, hold_zero,
               positioning_speed, intermediate_speed, high_speed,
               motor_energised,
        input  drive_ready, brake_release, travel_active
    );
endinterface

//--- logic/qhs_pkg.sv
// types for the quickstart hold sequencer
package qhs_pkg;
    typedef enum logic [2:0] {
        QHS_IDLE   = 3'b000,
        QHS_READY  = 3'b001,
        QHS_HOLD   = 3'b011,
        QHS_TRAVEL = 3'b010,
        QHS_FAULT  = 3'b110
    } qhs_state_e;
endpackage

//--- sim/qhs_assertions.sv
// assertions on the link between lift controller and drive
`timescale 1ns/10ps
module qhs_assertions (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic controller_enable,
    input wire logic travel_direction,
    input wire logic hold_zero,
    input wire logic positioning_speed,
    input wire logic intermediate_speed,
    input wire logic high_speed,
    input wire logic motor_energised,
    input wire logic drive_ready,
    input wire logic brake_release,
    input wire logic travel_active
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    wire logic [2:0] spd = {positioning_speed, intermediate_speed, high_speed};
    property p_rdy;
        $rose(drive_ready) |->
            $past(controller_enable, 2) && $past(hold_zero, 2);
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready unasked");
    property p_brk;
        $rose(brake_release) |-> $past(motor_energised, 2) && drive_ready;
    endproperty
    a_brk: assert property (p_brk) else $error("brake early");
    property p_brk_rdy;
        brake_release |-> drive_ready;
    endproperty
    a_brk_rdy: assert property (p_brk_rdy)
        else $error("brake no ready");
    property p_act;
        travel_active == drive_ready;
    endproperty
    a_act: assert property (p_act) else $error("active wrong");
    property p_drop;
        $fell(controller_enable) |-> ##[1:4] !drive_ready;
    endproperty
    a_drop: assert property (p_drop) else $error("ready stuck");
    property p_one;
        $onehot0(spd);
    endproperty
    a_one: assert property (p_one) else $error("two speeds");
    property p_early;
        |spd |-> !hold_zero;
    endproperty
    a_early: assert property (p_early) else $error("speed in hold");
    property p_hdrop;
        $fell(hold_zero) && controller_enable |-> $past(brake_release);
    endproperty
    a_hdrop: assert property (p_hdrop)
        else $error("hold drop early");
    property p_spd;
        $fell(hold_zero) && controller_enable |-> ##[0:3] |spd;
    endproperty
    a_spd: assert property (p_spd) else $error("speed late");
    c_brk: cover property ($rose(brake_release));
    c_go: cover property ($fell(hold_zero) && controller_enable);
    c_end: cover property ($fell(drive_ready));
endmodule

//--- sim/tb.sv
// self-checking bench for the quickstart hold sequencer pair
`timescale 1ns/10ps
module tb;
    import qhs_pkg::*;
    localparam int unsigned HOLD = 200;
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic               closing = 1'b0;
    logic               closed = 1'b0;
    logic               dir = 1'b0;
    logic               tend = 1'b0;
    logic [1:0]         sel = 2'h0;
    logic               clr1 = 1'b0;
    logic               clr2 = 1'b0;
    logic signed [15:0] pos1 = 16'sh0064;
    logic signed [15:0] pos2 = 16'sh0000;
    logic               trav, zs1, zs2, en1, en2, f1, f2;
    logic [7:0]         e1, e2;
    int                 err_count = 0;
    int                 samples_checked = 0;
    int                 cycles = 0;
    int                 n1 = 0;
    int                 n2 = 0;
    int                 k;
    qhs_link_if lk ();
    qhs_link_if lk2 ();
    qhs_ctrl qhs_ctrl_i (.mclk_in(clk), .rstn_in(rstn),
        .door_closing_in(closing), .door_closed_in(closed),
        .direction_in(dir), .speed_sel_in(sel), .trip_end_in(tend),
        .travelling_out(trav), .link(lk));
    qhs_drive #(.HOLD_CYCLES(HOLD)) qhs_drive_i (.mclk_in(clk),
        .rstn_in(rstn), .link(lk), .position_mm_in(pos1),
        .fault_clear_in(clr1), .zero_speed_reg_out(zs1),
        .encoder_sup_start_out(en1), .error_code_out(e1), .fault_out(f1));
    qhs_drive #(.HOLD_CYCLES(HOLD)) qhs_drive_i2 (.mclk_in(clk),
        .rstn_in(rstn), .link(lk2), .position_mm_in(pos2),
        .fault_clear_in(clr2), .zero_speed_reg_out(zs2),
        .encoder_sup_start_out(en2), .error_code_out(e2), .fault_out(f2));
    qhs_assertions qhs_assertions_i (.mclk_in(clk), .rstn_in(rstn),
        .controller_enable(lk.controller_enable),
        .travel_direction(lk.travel_direction), .hold_zero(lk.hold_zero),
        .positioning_speed(lk.positioning_speed),
        .intermediate_speed(lk.intermediate_speed),
        .high_speed(lk.high_speed), .motor_energised(lk.motor_energised),
        .drive_ready(lk.drive_ready), .brake_release(lk.brake_release),
        .travel_active(lk.travel_active));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (en1 === 1'b1) n1++;
        if (en2 === 1'b1) n2++;
        if (cycles == 6000) begin
            err_count++;
            summarize();
        end
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // enable, hold, motor, high speed of the rule-breaking far side
    task drv(input logic [3:0] v);
        {lk2.controller_enable, lk2.hold_zero} = v[3:2];
        {lk2.motor_energised, lk2.high_speed} = v[1:0];
    endtask
    task clear2();
        drv(4'h0);
        clr2 = 1'b1;
        cyc(6);
        clr2 = 1'b0;
        cyc(2);
        chk(f2, 0, "fault");
        chk(e2, 0, "code");
    endtask
    function automatic logic [2:0] spd(input logic [1:0] s);
        return (s < 2) ? 3'h4 : (s == 2) ? 3'h2 : 3'h1;
    endfunction
    task summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        drv(4'h0);
        lk2.travel_direction = 1'b1;
        lk2.positioning_speed = 1'b0;
        lk2.intermediate_speed = 1'b0;
        void'($urandom(32'h4e8d));
        cyc(10);
        rstn = 1'b1;
        cyc(2);
        for (int t = 0; t < 6; t++) begin
            // first four trips walk every speed select value
            sel = (t < 4) ? 2'(t) : 2'($urandom_range(0, 3));
            dir = 1'($urandom_range(0, 1));
            closing = 1'b1;
            for (k = 0; k < 20 && lk.brake_release !== 1'b1; k++) cyc(1);
            chk(lk.drive_ready, 1, "ready");
            chk(lk.travel_active, 1, "active");
            chk(lk.brake_release, 1, "brake");
            chk(lk.travel_direction, dir, "dir");
            cyc(2);
            chk(zs1, 1, "zero reg");
            // creep jitter stays inside the window
            for (k = $urandom_range(0, 40); k > 0; k--) begin
                pos1 = 16'sd97 + 16'($urandom_range(0, 6));
                cyc(1);
            end
            closed = 1'b1;
            for (k = 0; k < 10 && lk.hold_zero !== 1'b0; k++) cyc(1);
            cyc(4);
            chk({lk.positioning_speed, lk.intermediate_speed,
                lk.high_speed}, spd(sel), "speed");
            chk(trav, 1, "travelling");
            chk(zs1, 0, "zero reg");
            chk(n1[7:0], 8'(t + 1), "enc start");
            chk(f1, 0, "fault");
            chk(e1, 8'h00, "code");
            closing = 1'b0;
            closed = 1'b0;
            tend = 1'b1;
            for (k = 0; k < 20 && lk.drive_ready !== 1'b0; k++) cyc(1);
            chk(lk.drive_ready, 0, "ready");
            chk(lk.brake_release, 0, "brake");
            chk(trav, 0, "travelling");
            tend = 1'b0;
            cyc(4);
        end
        drv(4'he);
        cyc(10);
        chk(lk2.brake_release, 1, "brake");
        pos2 = 16'sd7;
        cyc(5);
        chk(f2, 0, "fault");
        cyc(HOLD - 25);
        chk(f2, 0, "fault");
        cyc(30);
        chk(e2, 8'h01, "code");
        chk(lk2.drive_ready, 0, "ready");
        chk(lk2.brake_release, 0, "brake");
        clear2();
        pos2 = 16'sd0;
        drv(4'he);
        cyc(10);
        pos2 = -16'sd8;
        cyc(6);
        chk(e2, 8'h03, "code");
        chk(f2, 1, "fault");
        clear2();
        pos2 = 16'sd0;
        drv(4'he);
        cyc(10);
        k = n2;
        drv(4'hb);
        cyc(6);
        chk(n2[7:0], 8'(k + 1), "enc start");
        chk(zs2, 0, "zero reg");
        chk(lk2.brake_release, 1, "brake");
        drv(4'hf);
        cyc(6);
        chk(e2, 8'h02, "code");
        clear2();
        summarize();
    end
endmodule
